// *** verilog/aab_alu_core.sv ***
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Accumulator datapath with add, and, bit clear and status flags,
// reached by software over an APB slave port.
module aab_alu_core #(
    parameter int ADDR_W = 12
) (
    input logic clock_i,
    input logic rst_n_i,
    // APB slave
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [ADDR_W-1:0] paddr_i,
    input logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Watchdog counter overflow event, one cycle pulse
    input logic wdt_overflow_i,
    // Datapath state seen by the rest of the core
    output logic [7:0] accumulator_o,
    output logic power_down_flag_o,
    output logic watchdog_timeout_flag_o,
    output logic halt_pulse_o,
    output logic wdt_clear_pulse_o
);

    // All module state
    typedef struct packed {
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic pd;
        logic to;
        logic halt;
        logic wdt_clr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } aab_core_state_s;

    aab_core_state_s st_q;
    aab_core_state_s st_d;

    logic [11:0] addr;
    logic access_first;
    logic access_done;
    logic wr_done;
    logic hit_instr;
    logic hit_acc;
    logic hit_status;
    logic hit_sfr;
    logic hit_any;
    logic [4:0] sfr_bus_idx;
    logic [7:0] sfr_bus_rd;
    logic [7:0] sfr_exec_rd;
    aab_pkg::aab_instr_s instr;
    logic exec_go;
    logic [7:0] alu_b;
    logic alu_cin;
    aab_pkg::aab_alu_res_s alu_res;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic [7:0] and_res;
    logic [7:0] clr_res;
    logic [7:0] bit_mask;
    logic [31:0] status_word;

    // Bus address widened or cut to the decoder width
    assign addr = 12'(paddr_i);

    // Address decode for the four register groups
    always_comb begin
        hit_instr = 1'b0;
        hit_acc = 1'b0;
        hit_status = 1'b0;
        hit_sfr = 1'b0;
        if (addr == aab_pkg::OFS_INSTR) begin
            hit_instr = 1'b1;
        end else if (addr == aab_pkg::OFS_ACC) begin
            hit_acc = 1'b1;
        end else if (addr == aab_pkg::OFS_STATUS) begin
            hit_status = 1'b1;
        end else if (addr >= aab_pkg::OFS_SFR_BASE && addr <= aab_pkg::OFS_SFR_LAST
                     && addr[1:0] == 2'h0) begin
            hit_sfr = 1'b1;
        end
    end

    assign hit_any = hit_instr | hit_acc | hit_status | hit_sfr;

    // Word index of a special register in the bus window
    assign sfr_bus_idx = addr[6:2];

    // One wait state: data is registered in the first access cycle,
    // so every output stays a flip-flop.
    assign access_first = psel_i & penable_i & ~st_q.pready;
    assign access_done = psel_i & penable_i & st_q.pready;
    assign wr_done = access_done & pwrite_i & hit_any;

    // Instruction issue happens at the completing edge of its write
    assign instr = aab_pkg::aab_instr_s'(pwdata_i[20:0]);
    assign exec_go = wr_done & hit_instr;

    // Status word as software sees it
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[aab_pkg::STAT_C_BIT] = st_q.c;
        status_word[aab_pkg::STAT_DC_BIT] = st_q.dc;
        status_word[aab_pkg::STAT_Z_BIT] = st_q.z;
        status_word[aab_pkg::STAT_PD_BIT] = st_q.pd;
        status_word[aab_pkg::STAT_TO_BIT] = st_q.to;
    end

    // Second operand: immediate for the immediate forms, else the register
    always_comb begin
        alu_b = sfr_exec_rd;
        alu_cin = 1'b0;
        case (aab_pkg::aab_op_e'(instr.op))
            aab_pkg::OP_ADD_REG_C: begin
                // [RL6] Carry joins register plus accumulator
                alu_cin = st_q.c;
            end
            aab_pkg::OP_ADD_IMM_C: begin
                // [RL9] Immediate with carry
                alu_b = instr.imm;
                alu_cin = st_q.c;
            end
            aab_pkg::OP_ADD_IMM: begin
                // [RL10] Immediate, no carry in
                alu_b = instr.imm;
            end
            default: begin
                alu_cin = 1'b0;
            end
        endcase
    end

    aab_adder aab_adder_inst (
        .a_i(st_q.acc),
        .b_i(alu_b),
        .cin_i(alu_cin),
        .res_o(alu_res)
    );

    // Logic results that bypass the adder
    assign and_res = st_q.acc & sfr_exec_rd;
    assign bit_mask = 8'h01 << instr.bitpos;
    // [RL12] Only the chosen bit is dropped
    assign clr_res = sfr_exec_rd & ~bit_mask;

    // Register file write: instruction writeback or a bus write.
    // Both cannot happen together because only one transfer is open.
    always_comb begin
        rf_we = 1'b0;
        rf_waddr = instr.raddr;
        rf_wdata = 8'h00;
        if (exec_go) begin
            case (aab_pkg::aab_op_e'(instr.op))
                aab_pkg::OP_ADD_REG_C, aab_pkg::OP_ADD_REG: begin
                    // [RL7] Destination one goes back to the register
                    rf_we = instr.dest;
                    rf_wdata = alu_res.sum;
                end
                aab_pkg::OP_AND_REG: begin
                    // [RL7] Same routing for the logic result
                    rf_we = instr.dest;
                    rf_wdata = and_res;
                end
                aab_pkg::OP_CLR_BIT: begin
                    rf_we = 1'b1;
                    rf_wdata = clr_res;
                end
                default: begin
                    rf_we = 1'b0;
                end
            endcase
        end else if (wr_done && hit_sfr) begin
            rf_we = 1'b1;
            rf_waddr = sfr_bus_idx;
            rf_wdata = pwdata_i[7:0];
        end
    end

    // [RL5] Register operand is a five-bit index, 0x0 to 0x1F
    aab_regfile #(
        .DEPTH(aab_pkg::SFR_COUNT),
        .AW(5)
    ) aab_regfile_inst (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .we_i(rf_we),
        .waddr_i(rf_waddr),
        .wdata_i(rf_wdata),
        .raddr_a_i(instr.raddr),
        .rdata_a_o(sfr_exec_rd),
        .raddr_b_i(sfr_bus_idx),
        .rdata_b_o(sfr_bus_rd)
    );

    // Next state of bus answer, accumulator and flags
    always_comb begin
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.halt = 1'b0;
        st_d.wdt_clr = 1'b0;

        // Read data and error are captured in the first access cycle
        if (access_first) begin
            st_d.pready = 1'b1;
            st_d.pslverr = ~hit_any;
            if (pwrite_i || !hit_any) begin
                st_d.prdata = 32'h0000_0000;
            end else if (hit_acc) begin
                st_d.prdata = {24'h00_0000, st_q.acc};
            end else if (hit_status) begin
                st_d.prdata = status_word;
            end else if (hit_sfr) begin
                st_d.prdata = {24'h00_0000, sfr_bus_rd};
            end else begin
                // Instruction word is write-only and reads as zero
                st_d.prdata = 32'h0000_0000;
            end
        end else begin
            st_d.pslverr = 1'b0;
        end

        // Direct software writes to accumulator and arithmetic flags
        if (wr_done && hit_acc) begin
            st_d.acc = pwdata_i[7:0];
        end
        if (wr_done && hit_status) begin
            st_d.c = pwdata_i[aab_pkg::STAT_C_BIT];
            st_d.dc = pwdata_i[aab_pkg::STAT_DC_BIT];
            st_d.z = pwdata_i[aab_pkg::STAT_Z_BIT];
        end

        // Instruction execution, all in the issuing cycle
        if (exec_go) begin
            case (aab_pkg::aab_op_e'(instr.op))
                aab_pkg::OP_ADD_REG_C, aab_pkg::OP_ADD_REG: begin
                    // [RL8] Sum to accumulator when destination is zero
                    if (!instr.dest) begin
                        st_d.acc = alu_res.sum;
                    end
                    // [RL13] Carry and digit carry from the adder
                    st_d.c = alu_res.c;
                    st_d.dc = alu_res.dc;
                    // [RL14] Zero result test
                    st_d.z = (alu_res.sum == 8'h00);
                end
                aab_pkg::OP_ADD_IMM_C, aab_pkg::OP_ADD_IMM: begin
                    // [RL10] Immediate forms always land in accumulator
                    st_d.acc = alu_res.sum;
                    st_d.c = alu_res.c;
                    // [RL15] Nibble carry kept
                    st_d.dc = alu_res.dc;
                    st_d.z = (alu_res.sum == 8'h00);
                end
                aab_pkg::OP_AND_REG: begin
                    // [RL11] Zero flag only
                    if (!instr.dest) begin
                        st_d.acc = and_res;
                    end
                    st_d.z = (and_res == 8'h00);
                end
                aab_pkg::OP_WDT_CLEAR: begin
                    // [RL1] Watchdog clear raises power-down flag
                    st_d.pd = 1'b1;
                    // [RL3] And the timeout flag
                    st_d.to = 1'b1;
                    st_d.wdt_clr = 1'b1;
                end
                aab_pkg::OP_HALT: begin
                    // [RL2] Halt drops power-down flag
                    st_d.pd = 1'b0;
                    // [RL3] Halt raises timeout flag
                    st_d.to = 1'b1;
                    st_d.halt = 1'b1;
                end
                default: begin
                    // Clear-bit and no-op leave flags alone
                    st_d.halt = 1'b0;
                end
            endcase
        end

        // [RL4] Overflow clears timeout; placed last so the event is never lost
        if (wdt_overflow_i) begin
            st_d.to = 1'b0;
        end
    end

    // State register; power-down and timeout flags come up set as after power-up, C, DC and Z clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q.acc <= aab_pkg::ACC_RST;
            st_q.c <= 1'b0;
            st_q.dc <= 1'b0;
            st_q.z <= 1'b0;
            // [RL1] Power-up value
            st_q.pd <= aab_pkg::PD_RST;
            // [RL3] Power-up value
            st_q.to <= aab_pkg::TO_RST;
            st_q.halt <= 1'b0;
            st_q.wdt_clr <= 1'b0;
            st_q.prdata <= 32'h0000_0000;
            st_q.pready <= 1'b0;
            st_q.pslverr <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign prdata_o = st_q.prdata;
    assign pready_o = st_q.pready;
    assign pslverr_o = st_q.pslverr;
    assign accumulator_o = st_q.acc;
    assign power_down_flag_o = st_q.pd;
    assign watchdog_timeout_flag_o = st_q.to;
    assign halt_pulse_o = st_q.halt;
    assign wdt_clear_pulse_o = st_q.wdt_clr;

endmodule // aab_alu_core

// *** verilog/aab_pkg.sv ***
// Function
// [RL1] The power-down flag becomes 1 at power-up and whenever the watchdog-clear instruction runs.
// [RL2] The power-down flag becomes 0 whenever the halt-mode instruction runs.
// [RL3] The watchdog-timeout flag becomes 1 at power-up, on watchdog-clear and on halt-mode.
// [RL4] The watchdog-timeout flag becomes 0 when the watchdog counter overflows.
// [RL5] The register operand of a data instruction addresses special registers 0x0 to 0x1F.
// [RL6] Add-register-with-carry forms register plus accumulator plus carry in one cycle, updating Z, DC and C.
// [RL7] Register-operand arithmetic and logic results go to the accumulator if dest is 0, else back to the register.
// [RL8] Add-register forms accumulator plus register without carry-in in one cycle, updating Z, DC and C.
// [RL9] Add-immediate-with-carry adds accumulator, 8-bit immediate and carry into the accumulator in one cycle, updating Z, DC and C.
// [RL10] Add-immediate adds an 8-bit immediate to the accumulator without carry-in in one cycle, updating Z, DC and C.
// [RL11] And-register ANDs accumulator and register in one cycle, routes by dest and updates only Z.
// [RL12] Clear-bit forces bit 0 to 7 of the addressed register to zero in one cycle, touching no flag.
// [RL13] Carry is 1 when an addition carries out (or a subtraction does not borrow), else 0.
// [RL14] Zero is 1 when the 8-bit result of a flag-affecting instruction is zero, else 0.
// [RL15] Digit carry is 1 when an addition carries from bit 3 into bit 4, else 0.
package aab_pkg;

    // Register byte offsets on the APB window
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_ACC = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_SFR_BASE = 12'h080;
    localparam logic [11:0] OFS_SFR_LAST = 12'h0FC;

    // Status register bit positions
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;

    // Values after reset
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] SFR_RST = 8'h00;
    localparam logic PD_RST = 1'b1;
    localparam logic TO_RST = 1'b1;

    // Number of special registers reachable by the register operand
    localparam int SFR_COUNT = 32;

    // Instruction codes held in the instruction word
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_REG_C = 4'h1,
        OP_ADD_REG = 4'h2,
        OP_ADD_IMM_C = 4'h3,
        OP_ADD_IMM = 4'h4,
        OP_AND_REG = 4'h5,
        OP_CLR_BIT = 4'h6,
        OP_WDT_CLEAR = 4'h7,
        OP_HALT = 4'h8
    } aab_op_e;

    // Instruction word, occupying pwdata[20:0]
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] bitpos;
        logic dest;
        logic [4:0] raddr;
        logic [7:0] imm;
    } aab_instr_s;

    // Adder result with its flags
    typedef struct packed {
        logic [7:0] sum;
        logic dc;
        logic c;
    } aab_alu_res_s;

endpackage

// *** verilog/aab_adder.sv ***
`timescale 1ns/1ps
// Eight-bit adder that also reports the nibble carry
module aab_adder (
    input logic [7:0] a_i,
    input logic [7:0] b_i,
    input logic cin_i,
    output aab_pkg::aab_alu_res_s res_o
);

    logic [4:0] lo_sum;
    logic [4:0] hi_sum;

    // Split into nibbles so the digit carry falls out without a second adder
    always_comb begin
        lo_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
        hi_sum = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo_sum[4]};
        res_o.sum = {hi_sum[3:0], lo_sum[3:0]};
        // [RL15] Nibble carry out
        res_o.dc = lo_sum[4];
        // [RL13] Carry out
        res_o.c = hi_sum[4];
    end

endmodule // aab_adder

// *** verilog/aab_regfile.sv ***
`timescale 1ns/1ps
// Special register file, one write port and two read ports
module aab_regfile #(
    parameter int DEPTH = aab_pkg::SFR_COUNT,
    parameter int AW = 5
) (
    input logic clock_i,
    input logic rst_n_i,
    input logic we_i,
    input logic [AW-1:0] waddr_i,
    input logic [7:0] wdata_i,
    input logic [AW-1:0] raddr_a_i,
    output logic [7:0] rdata_a_o,
    input logic [AW-1:0] raddr_b_i,
    output logic [7:0] rdata_b_o
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } aab_rf_state_s;

    aab_rf_state_s st_q;
    aab_rf_state_s st_d;

    // Next state: one entry changes per cycle at most
    always_comb begin
        st_d = st_q;
        if (we_i) begin
            st_d.mem[waddr_i] = wdata_i;
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q <= {DEPTH{aab_pkg::SFR_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    // Read ports see the stored value, not the one being written
    assign rdata_a_o = st_q.mem[raddr_a_i];
    assign rdata_b_o = st_q.mem[raddr_b_i];

endmodule // aab_regfile

// *** sim/aab_alu_core_properties.sv ***
`timescale 1ns/1ps
// Port-level watch on bus timing, accumulator writes and watchdog status flags
module aab_alu_props #(
    parameter int ADDR_W = 12
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic wdt_overflow_i,
    input wire logic [7:0] accumulator_o,
    input wire logic power_down_flag_o,
    input wire logic watchdog_timeout_flag_o,
    input wire logic halt_pulse_o,
    input wire logic wdt_clear_pulse_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // Bus phases
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence access_s;
        psel_i && penable_i;
    endsequence

    ready_wait_a: assert property (setup_s ##1 access_s |-> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    err_with_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    // A commit is the only thing allowed to move the accumulator
    acc_by_write_a: assert property (!$stable(accumulator_o) |-> $past(psel_i && penable_i && pready_o && pwrite_i))
        else $error("accumulator moved without a write");
    pd_halt_a: assert property (halt_pulse_o |-> !power_down_flag_o)
        else $error("power down flag set after halt");
    pd_clear_a: assert property (wdt_clear_pulse_o |-> power_down_flag_o)
        else $error("power down flag clear after watchdog clear");
    pd_rise_a: assert property ($rose(power_down_flag_o) |-> wdt_clear_pulse_o)
        else $error("power down flag rose without cause");
    pd_fall_a: assert property ($fell(power_down_flag_o) |-> halt_pulse_o)
        else $error("power down flag fell without halt");
    // Overflow at the executing edge wins over the set
    to_set_a: assert property ((halt_pulse_o || wdt_clear_pulse_o) && !$past(wdt_overflow_i) |-> watchdog_timeout_flag_o)
        else $error("timeout flag not set");
    to_rise_a: assert property ($rose(watchdog_timeout_flag_o) |-> halt_pulse_o || wdt_clear_pulse_o)
        else $error("timeout flag rose without cause");
    to_clear_a: assert property (wdt_overflow_i |=> !watchdog_timeout_flag_o)
        else $error("timeout flag kept after overflow");
endmodule // aab_alu_props

// *** sim/aab_alu_core_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench driving the datapath through its register port
module aab_alu_core_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic wdt_ovf = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] acc;
    logic pd;
    logic tof;
    logic halt_p;
    logic clr_p;
    logic [31:0] rd;
    logic serr;
    int err_total = 0;
    int checks_done = 0;

    aab_alu_core #(.ADDR_W(12)) aab_alu_core_inst (
        .clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .wdt_overflow_i(wdt_ovf),
        .accumulator_o(acc), .power_down_flag_o(pd), .watchdog_timeout_flag_o(tof),
        .halt_pulse_o(halt_p), .wdt_clear_pulse_o(clr_p)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One transfer, held until ready is sampled; bounded so a dead slave cannot hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // Instruction word with register operand fixed at 5
    function automatic logic [31:0] ins(input logic [3:0] op, input logic [2:0] b,
        input logic d, input logic [7:0] i);
        return {11'h000, op, b, d, 5'h05, i};
    endfunction

    // Preload, execute, read back accumulator, register 5 and status
    task automatic run(input logic [7:0] a, input logic [7:0] r, input logic [2:0] st,
        input logic [31:0] w, input logic [7:0] ea, input logic [7:0] ereg, input logic [7:0] es);
        wr(12'h004, {24'h000000, a});
        wr(12'h094, {24'h000000, r});
        wr(12'h008, {29'h00000000, st});
        wr(12'h000, w);
        rchk(12'h004, {24'h000000, ea});
        // Port must agree with the bus view once the result has landed
        chk({24'h000000, acc}, {24'h000000, ea});
        rchk(12'h094, {24'h000000, ereg});
        rchk(12'h008, {24'h000000, es});
    endtask

    task automatic t_reset;
        chk({30'h0, pd, tof}, 32'h3);
        rchk(12'h008, 32'h00000018);
        rchk(12'h080, 32'h00000000);
    endtask

    task automatic t_arith;
        run(8'h12, 8'h34, 3'h1, ins(4'h1, 3'h0, 1'b1, 8'h00), 8'h12, 8'h47, 8'h18);
        run(8'hF8, 8'h08, 3'h0, ins(4'h2, 3'h0, 1'b0, 8'h00), 8'h00, 8'h08, 8'h1F);
        run(8'h12, 8'h34, 3'h1, ins(4'h2, 3'h0, 1'b1, 8'h00), 8'h12, 8'h46, 8'h18);
        run(8'h12, 8'h99, 3'h1, ins(4'h3, 3'h0, 1'b0, 8'h34), 8'h47, 8'h99, 8'h18);
        run(8'hFF, 8'h99, 3'h1, ins(4'h3, 3'h0, 1'b0, 8'h00), 8'h00, 8'h99, 8'h1F);
        run(8'h12, 8'h99, 3'h1, ins(4'h4, 3'h0, 1'b0, 8'h34), 8'h46, 8'h99, 8'h18);
        run(8'h0F, 8'h99, 3'h0, ins(4'h4, 3'h0, 1'b1, 8'h01), 8'h10, 8'h99, 8'h1A);
    endtask

    task automatic t_logic;
        run(8'h5A, 8'hAF, 3'h7, ins(4'h5, 3'h0, 1'b1, 8'h00), 8'h5A, 8'h0A, 8'h1B);
        run(8'h0F, 8'hF0, 3'h0, ins(4'h5, 3'h0, 1'b0, 8'h00), 8'h00, 8'hF0, 8'h1C);
        run(8'h00, 8'h5A, 3'h7, ins(4'h6, 3'h3, 1'b0, 8'h00), 8'h00, 8'h52, 8'h1F);
        run(8'h00, 8'hFF, 3'h0, ins(4'h6, 3'h7, 1'b1, 8'h00), 8'h00, 8'h7F, 8'h18);
        run(8'h33, 8'h44, 3'h5, ins(4'h0, 3'h0, 1'b1, 8'h00), 8'h33, 8'h44, 8'h1D);
    endtask

    // Last special register, unmapped and misaligned places, read-only flags
    task automatic t_bus;
        wr(12'h0FC, 32'hFFFFFFA5);
        rchk(12'h0FC, 32'h000000A5);
        chk({31'h0, serr}, 32'h0);
        rchk(12'h100, 32'h00000000);
        chk({31'h0, serr}, 32'h1);
        wr(12'h0FE, 32'h00000011);
        chk({31'h0, serr}, 32'h1);
        rchk(12'h0FC, 32'h000000A5);
        wr(12'h008, 32'h00000000);
        rchk(12'h008, 32'h00000018);
    endtask

    task automatic ovf_pulse;
        @(posedge clk);
        wdt_ovf <= 1'b1;
        @(posedge clk);
        wdt_ovf <= 1'b0;
        @(posedge clk);
    endtask

    // Flags and the one-cycle pulses are read the cycle after the commit edge
    task automatic t_wdt;
        ovf_pulse();
        chk({30'h0, pd, tof}, 32'h2);
        wr(12'h000, ins(4'h8, 3'h0, 1'b0, 8'h00));
        @(posedge clk);
        chk({30'h0, pd, tof}, 32'h1);
        chk({30'h0, halt_p, clr_p}, 32'h2);
        ovf_pulse();
        chk({30'h0, pd, tof}, 32'h0);
        wr(12'h000, ins(4'h7, 3'h0, 1'b0, 8'h00));
        @(posedge clk);
        chk({30'h0, pd, tof}, 32'h3);
        chk({30'h0, halt_p, clr_p}, 32'h1);
        rchk(12'h008, 32'h00000018);
        chk({30'h0, halt_p, clr_p}, 32'h0);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_arith();
        t_logic();
        t_bus();
        t_wdt();
        complete_run();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule // aab_alu_core_bench

bind aab_alu_core aab_alu_props #(.ADDR_W(ADDR_W)) aab_alu_props_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .wdt_overflow_i(wdt_overflow_i),
    .accumulator_o(accumulator_o), .power_down_flag_o(power_down_flag_o),
    .watchdog_timeout_flag_o(watchdog_timeout_flag_o), .halt_pulse_o(halt_pulse_o),
    .wdt_clear_pulse_o(wdt_clear_pulse_o)
);
